// ---- rtl/drc_defs.vh ----
`ifndef DRC_DEFS_VH
`define DRC_DEFS_VH

// register addresses on the plain port
`define DRC_ADDR_W 1
`define DRC_ADDR_CONTROL_0 1'h0
`define DRC_ADDR_LEVEL_CODE 1'h1

// ref_control_0 field positions
`define DRC_BIT_ENABLE 7
`define DRC_BIT_PIN1_OE 5
`define DRC_BIT_PIN2_OE 4
`define DRC_PSS_HI 3
`define DRC_PSS_LO 2
`define DRC_BIT_NSS 0

// implemented bits of ref_control_0
`define DRC_CONTROL_0_MASK 8'hbd

// reset values
`define DRC_CONTROL_0_RST 8'h00
`define DRC_LEVEL_CODE_RST 8'h00

// positive source codes
`define DRC_PSS_SUPPLY 2'h0
`define DRC_PSS_REF_PIN 2'h1
`define DRC_PSS_FIXED_REF 2'h2
`define DRC_PSS_RESERVED 2'h3

`endif

// ---- rtl/drc_dac_reference_control.v ----
`timescale 1ns/100ps
`default_nettype none
`include "drc_defs.vh"

module drc_dac_reference_control (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [`DRC_ADDR_W-1:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [7:0] rdata_o,
  input wire pin1_digital_in_i,
  input wire pin2_digital_in_i,
  input wire pin1_digital_oe_i,
  input wire pin2_digital_oe_i,
  output reg converter_enable_o,
  output reg [7:0] ladder_code_o,
  output reg [1:0] positive_source_select_o,
  output reg negative_source_select_o,
  output reg source_supply_o,
  output reg source_ref_pin_o,
  output reg source_fixed_ref_o,
  output reg neg_ref_pin_o,
  output reg reference_out_pin_1_o,
  output reg reference_out_pin_2_o,
  output reg pin1_driver_enable_o,
  output reg pin2_driver_enable_o,
  output reg pin1_detector_enable_o,
  output reg pin2_detector_enable_o,
  output reg pin1_read_o,
  output reg pin2_read_o
);

  // register file
  reg [7:0] ref_control_0_reg;
  reg [7:0] ref_control_0_next;
  reg [7:0] ref_level_code_reg;
  reg [7:0] ref_level_code_next;
  reg [7:0] rdata_next;

  // strobe decode
  reg wr_control_0;
  reg wr_level_code;
  reg rd_control_0;
  reg rd_level_code;

  // fields of the control value that the outputs will hold
  wire en;
  wire oe1;
  wire oe2;
  wire [1:0] pss;
  wire nss;

  // next values of the switch and pin outputs
  reg supply_next;
  reg ref_pin_next;
  reg fixed_ref_next;
  reg neg_ref_pin_next;
  reg out_pin_1_next;
  reg out_pin_2_next;
  reg pin1_driver_next;
  reg pin2_driver_next;
  reg pin1_detector_next;
  reg pin2_detector_next;
  reg pin1_read_next;
  reg pin2_read_next;

  // one register per address; the bus never asks for both at once
  always @* begin
    wr_control_0 = 1'b0;
    wr_level_code = 1'b0;
    rd_control_0 = 1'b0;
    rd_level_code = 1'b0;
    if (addr_i == `DRC_ADDR_CONTROL_0) begin
      wr_control_0 = wr_i;
      rd_control_0 = rd_i;
    end else if (addr_i == `DRC_ADDR_LEVEL_CODE) begin
      wr_level_code = wr_i;
      rd_level_code = rd_i;
    end
  end

  // no sleep input: only a write or reset changes the registers
  always @* begin
    ref_control_0_next = ref_control_0_reg;
    ref_level_code_next = ref_level_code_reg;
    if (wr_control_0) begin
      ref_control_0_next = wdata_i & `DRC_CONTROL_0_MASK;
    end
    if (wr_level_code) begin
      ref_level_code_next = wdata_i;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_control_0_reg <= `DRC_CONTROL_0_RST;
    end else begin
      ref_control_0_reg <= ref_control_0_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ref_level_code_reg <= `DRC_LEVEL_CODE_RST;
    end else begin
      ref_level_code_reg <= ref_level_code_next;
    end
  end

  // read data stand for one cycle and are zero otherwise
  always @* begin
    rdata_next = 8'h00;
    if (rd_control_0) begin
      rdata_next = ref_control_0_reg;
    end else if (rd_level_code) begin
      rdata_next = ref_level_code_reg;
    end
  end

  // outputs follow the next register value so they land on the edge
  // that takes the write
  assign en = ref_control_0_next[`DRC_BIT_ENABLE];
  assign oe1 = ref_control_0_next[`DRC_BIT_PIN1_OE];
  assign oe2 = ref_control_0_next[`DRC_BIT_PIN2_OE];
  assign pss = ref_control_0_next[`DRC_PSS_HI:`DRC_PSS_LO];
  assign nss = ref_control_0_next[`DRC_BIT_NSS];

  // source switches close only while enabled; the reserved code opens all
  always @* begin
    supply_next = 1'b0;
    ref_pin_next = 1'b0;
    fixed_ref_next = 1'b0;
    if (en) begin
      case (pss)
        `DRC_PSS_SUPPLY: begin
          supply_next = 1'b1;
        end
        `DRC_PSS_REF_PIN: begin
          ref_pin_next = 1'b1;
        end
        `DRC_PSS_FIXED_REF: begin
          fixed_ref_next = 1'b1;
        end
        default: begin
          supply_next = 1'b0;
        end
      endcase
    end
    neg_ref_pin_next = en && nss;
  end

  // pin override holds on the routing bit alone; the level reaches a pin
  // only while the converter runs
  always @* begin
    out_pin_1_next = en && oe1;
    out_pin_2_next = en && oe2;
    pin1_driver_next = pin1_digital_oe_i && !oe1;
    pin2_driver_next = pin2_digital_oe_i && !oe2;
    pin1_detector_next = !oe1;
    pin2_detector_next = !oe2;
    pin1_read_next = pin1_digital_in_i && !oe1;
    pin2_read_next = pin2_digital_in_i && !oe2;
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      converter_enable_o <= 1'b0;
    end else begin
      converter_enable_o <= en;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ladder_code_o <= 8'h00;
    end else begin
      // ladder taps: vout = vneg + (vpos - vneg) * code / 2^8
      ladder_code_o <= ref_level_code_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      positive_source_select_o <= 2'h0;
    end else begin
      positive_source_select_o <= pss;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      negative_source_select_o <= 1'b0;
    end else begin
      negative_source_select_o <= nss;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      source_supply_o <= 1'b0;
    end else begin
      source_supply_o <= supply_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      source_ref_pin_o <= 1'b0;
    end else begin
      source_ref_pin_o <= ref_pin_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      source_fixed_ref_o <= 1'b0;
    end else begin
      source_fixed_ref_o <= fixed_ref_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      neg_ref_pin_o <= 1'b0;
    end else begin
      neg_ref_pin_o <= neg_ref_pin_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reference_out_pin_1_o <= 1'b0;
    end else begin
      reference_out_pin_1_o <= out_pin_1_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reference_out_pin_2_o <= 1'b0;
    end else begin
      reference_out_pin_2_o <= out_pin_2_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin1_driver_enable_o <= 1'b0;
    end else begin
      pin1_driver_enable_o <= pin1_driver_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin2_driver_enable_o <= 1'b0;
    end else begin
      pin2_driver_enable_o <= pin2_driver_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin1_detector_enable_o <= 1'b1;
    end else begin
      pin1_detector_enable_o <= pin1_detector_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin2_detector_enable_o <= 1'b1;
    end else begin
      pin2_detector_enable_o <= pin2_detector_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin1_read_o <= 1'b0;
    end else begin
      pin1_read_o <= pin1_read_next;
    end
  end

  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin2_read_o <= 1'b0;
    end else begin
      pin2_read_o <= pin2_read_next;
    end
  end

endmodule // drc_dac_reference_control

`default_nettype wire

// ---- bench/drc_chk_sva.sv ----
`timescale 1ns/100ps
`default_nettype none
module drc_chk (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] ladder_code_o,
  input wire logic [1:0] positive_source_select_o,
  input wire logic converter_enable_o,
  input wire logic source_supply_o,
  input wire logic reference_out_pin_1_o,
  input wire logic pin1_detector_enable_o,
  input wire logic pin2_detector_enable_o,
  input wire logic pin2_driver_enable_o,
  input wire logic pin1_read_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_code_wr: assert property (
    wr_i && addr_i |=> ladder_code_o == $past(wdata_i))
    else $error("level code not taken from write");
  a_code_hold: assert property (
    !wr_i |=> $stable(ladder_code_o))
    else $error("level code moved without write");
  a_code_rd: assert property (
    rd_i && addr_i |=> rdata_o == $past(ladder_code_o))
    else $error("level code read wrong");
  a_enable_wr: assert property (
    wr_i && !addr_i |=> converter_enable_o == $past(wdata_i[7]))
    else $error("enable not taken from write");
  a_pin_route: assert property (
    reference_out_pin_1_o == (converter_enable_o && !pin1_detector_enable_o))
    else $error("pin routing wrong");
  a_pin_read: assert property (
    !pin1_detector_enable_o |-> !pin1_read_o)
    else $error("routed pin reads one");
  a_drv_off: assert property (
    !pin2_detector_enable_o |-> !pin2_driver_enable_o)
    else $error("routed pin still driven");
  a_supply_sel: assert property (
    source_supply_o == (converter_enable_o && positive_source_select_o == 2'h0))
    else $error("supply switch wrong");
  c_code_wr: cover property (wr_i && addr_i);
  c_ctrl_rd: cover property (rd_i && !addr_i);
  c_supply: cover property (source_supply_o);
endmodule // drc_chk
bind drc_dac_reference_control drc_chk u_drc_chk (.*);
`default_nettype wire

// ---- bench/drc_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys_i=0, rst_b_i=0, addr_i=0, wr_i=0, rd_i=0;
  logic pin1_digital_in_i=1, pin2_digital_in_i=1;
  logic pin1_digital_oe_i=1, pin2_digital_oe_i=1;
  logic [7:0] wdata_i=0;
  logic [2:0] s;
  wire [7:0] rdata_o, ladder_code_o;
  wire [1:0] positive_source_select_o;
  wire converter_enable_o, negative_source_select_o, source_supply_o;
  wire source_ref_pin_o, source_fixed_ref_o, neg_ref_pin_o, pin1_read_o;
  wire reference_out_pin_1_o, reference_out_pin_2_o, pin2_read_o;
  wire pin1_driver_enable_o, pin2_driver_enable_o;
  wire pin1_detector_enable_o, pin2_detector_enable_o;
  int err_total=0, check_count=0;
  drc_dac_reference_control u_drc_dac_reference_control (.*);
`define CHK(a,b) begin check_count++; if ((a)!==(b)) begin err_total++; \
  $display("mismatch %0t got %h want %h", $time, a, b); end end
  always #2 clk_sys_i = ~clk_sys_i;
  task wr(input logic a, input logic [7:0] d);
    addr_i <= a; wdata_i <= d; wr_i <= 1'b1; @(posedge clk_sys_i);
    wr_i <= 1'b0; @(posedge clk_sys_i);
  endtask
  task rd(input logic a, input logic [7:0] e);
    addr_i <= a; rd_i <= 1'b1; @(posedge clk_sys_i);
    rd_i <= 1'b0; #1 `CHK(rdata_o, e) @(posedge clk_sys_i);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1; @(posedge clk_sys_i);
    rd(0, 8'h00); rd(1, 8'h00);
    `CHK({converter_enable_o, pin1_detector_enable_o}, 2'h1)
    `CHK({reference_out_pin_1_o, reference_out_pin_2_o}, 2'h0)
    $display("reset value test done");
    wr(0, 8'hff); rd(0, 8'hbd);
    `CHK({reference_out_pin_1_o, pin1_read_o}, 2'h2)
    `CHK({reference_out_pin_2_o, pin2_read_o}, 2'h2)
    `CHK({pin1_driver_enable_o, pin2_driver_enable_o}, 2'h0)
    `CHK({pin1_detector_enable_o, pin2_detector_enable_o}, 2'h0)
    wr(0, 8'h90);
    `CHK({reference_out_pin_1_o, reference_out_pin_2_o}, 2'h1)
    `CHK({pin1_read_o, pin2_read_o}, 2'h2)
    `CHK({pin1_driver_enable_o, pin2_driver_enable_o}, 2'h2)
    `CHK({pin1_detector_enable_o, pin2_detector_enable_o}, 2'h2)
    pin1_digital_in_i <= 1'b0; pin1_digital_oe_i <= 1'b0;
    @(posedge clk_sys_i); @(posedge clk_sys_i);
    `CHK({pin1_read_o, pin1_driver_enable_o}, 2'h0)
    wr(0, 8'h30);
    `CHK(converter_enable_o, 1'b0)
    `CHK({reference_out_pin_1_o, reference_out_pin_2_o}, 2'h0)
    `CHK({pin1_detector_enable_o, pin2_read_o}, 2'h0)
    $display("routing test done");
    for (int i = 0; i < 4; i++) begin
      wr(0, {2'h2, 2'h0, i[1:0], 2'h1});
      s = {source_supply_o, source_ref_pin_o, source_fixed_ref_o};
      `CHK(s, 3'h4 >> i)
      `CHK(positive_source_select_o, i[1:0])
      `CHK({neg_ref_pin_o, negative_source_select_o}, 2'h3)
    end
    wr(0, 8'h80);
    s = {source_supply_o, neg_ref_pin_o, negative_source_select_o};
    `CHK(s, 3'h4)
    repeat (3) @(posedge clk_sys_i);
    rd(0, 8'h80);
    $display("source test done");
    wr(1, 8'h00); wr(1, 8'hff); rd(1, 8'hff);
    `CHK(ladder_code_o, 8'hff)
    $display("level code test done");
    rst_b_i <= 1'b0;
    #1 `CHK({converter_enable_o, ladder_code_o}, 9'h0)
    `CHK({pin1_detector_enable_o, pin2_detector_enable_o}, 2'h3)
    @(posedge clk_sys_i); rst_b_i <= 1'b1; @(posedge clk_sys_i);
    rd(1, 8'h00); rd(0, 8'h00);
    $display("reset test done");
    print_verdict;
  end
endmodule // tb
`default_nettype wire
